// >>> logic/bfls_defines.svh
`ifndef BFLS_DEFINES_SVH
`define BFLS_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses on the register bus)
// ----------------------------------------------------------------------
`define BFLS_OFF_CMD 12'h000
`define BFLS_OFF_DIRECT 12'h004
`define BFLS_OFF_STATUS_FLAGS 12'h008
`define BFLS_OFF_BUSY 12'h00C

// ----------------------------------------------------------------------
// status flag bit positions
// ----------------------------------------------------------------------
`define BFLS_FLAG_C 0
`define BFLS_FLAG_Z 1
`define BFLS_FLAG_N 2
`define BFLS_FLAG_V 3
`define BFLS_FLAG_S 4
`define BFLS_FLAG_H 5
`define BFLS_FLAG_T 6
`define BFLS_FLAG_I 7

// ----------------------------------------------------------------------
// reset values, pointer pair bases, cycle counts
// ----------------------------------------------------------------------
`define BFLS_RST_FLAGS 8'h00
`define BFLS_PTR_FIRST 5'h1A
`define BFLS_PTR_SECOND 5'h1C
`define BFLS_PTR_THIRD 5'h1E
`define BFLS_CYC_SINGLE 1
`define BFLS_CYC_MEM 2

`endif

// >>> logic/bfls_pkg.sv
package bfls_pkg;

    // ------------------------------------------------------------------
    // operations and phases
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_ROTATE_RIGHT_CARRY,
        OP_ARITH_SHIFT_RIGHT,
        OP_NIBBLE_SWAP,
        OP_FLAG_FORCE_ONE,
        OP_FLAG_FORCE_ZERO,
        OP_REG_BIT_TO_FLAG,
        OP_FLAG_TO_REG_BIT,
        OP_REG_COPY,
        OP_PAIR_COPY,
        OP_LOAD_PTR,
        OP_LOAD_INC,
        OP_LOAD_DEC,
        OP_LOAD_DISP,
        OP_LOAD_ABS,
        OP_STORE_PTR,
        OP_STORE_INC,
        OP_STORE_DEC
    } bfls_op_t;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_EXEC,
        PH_MEM
    } bfls_phase_t;

    // ------------------------------------------------------------------
    // command word, low bits first: op, rd, rr, bit, pointer, displacement
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [5:0] disp;
        logic [1:0] ptr;
        logic [2:0] bsel;
        logic [4:0] rr;
        logic [4:0] rd;
        bfls_op_t op;
    } bfls_cmd_t;

    typedef struct packed {
        logic we;
        logic [4:0] addr;
        logic [7:0] data;
    } bfls_rf_wr_t;

    typedef struct packed {
        logic we;
        logic [4:0] addr;
        logic [15:0] data;
    } bfls_pair_wr_t;

    typedef struct packed {
        logic re;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } bfls_dm_req_t;

    typedef struct packed {
        bfls_phase_t phase;
        bfls_cmd_t cmd;
        logic [15:0] direct;
        logic [7:0] flags;
        logic [15:0] ptr_next;
        bfls_rf_wr_t rf_wr;
        bfls_pair_wr_t pair_wr;
        bfls_dm_req_t dm;
        logic [31:0] prdata;
        logic pslverr;
    } bfls_state_t;

endpackage : bfls_pkg

// >>> logic/bfls_alu.sv
`include "bfls_defines.svh"

module bfls_alu (
    input wire bfls_pkg::bfls_op_t i_op,
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    input wire logic [2:0] i_bsel,
    input wire logic [7:0] i_flags,
    output logic [7:0] o_res,
    output logic [7:0] o_flags
);

    logic [7:0] sel_mask;

    assign sel_mask = 8'h01 << i_bsel;

    // ------------------------------------------------------------------
    // single cycle register and flag operations
    // ------------------------------------------------------------------
    always_comb begin
        o_res = i_a;
        o_flags = i_flags;
        unique case (i_op)
            bfls_pkg::OP_ROTATE_RIGHT_CARRY: begin
                o_res = {i_flags[`BFLS_FLAG_C], i_a[7:1]};
                o_flags[`BFLS_FLAG_C] = i_a[0];
            end
            bfls_pkg::OP_ARITH_SHIFT_RIGHT: begin
                o_res = {i_a[7], i_a[7:1]};
                o_flags[`BFLS_FLAG_C] = i_a[0];
            end
            bfls_pkg::OP_NIBBLE_SWAP: o_res = {i_a[3:0], i_a[7:4]};
            bfls_pkg::OP_FLAG_FORCE_ONE: o_flags = i_flags | sel_mask;
            bfls_pkg::OP_FLAG_FORCE_ZERO: o_flags = i_flags & ~sel_mask;
            bfls_pkg::OP_REG_BIT_TO_FLAG:
                o_flags[`BFLS_FLAG_T] = i_b[i_bsel];
            bfls_pkg::OP_FLAG_TO_REG_BIT: begin
                o_res = i_flags[`BFLS_FLAG_T] ? (i_a | sel_mask)
                    : (i_a & ~sel_mask);
            end
            bfls_pkg::OP_REG_COPY: o_res = i_b;
            default: o_res = i_a;
        endcase
        if (i_op == bfls_pkg::OP_ROTATE_RIGHT_CARRY
            || i_op == bfls_pkg::OP_ARITH_SHIFT_RIGHT) begin
            o_flags[`BFLS_FLAG_Z] = (o_res == 8'h00);
            o_flags[`BFLS_FLAG_N] = o_res[7];
            o_flags[`BFLS_FLAG_V] = o_res[7] ^ i_a[0];
        end
    end

endmodule : bfls_alu

// >>> logic/bfls_exec.sv
// Function
// - rotate right through carry, sets Z C N V, one cycle.
// - arithmetic shift right keeps bit 7, sets Z C N V, one cycle.
// - register bit to flag copies the chosen bit into T only, one cycle.
// - flag to register bit writes T into the chosen bit, no flags, 1 cycle.
// - flag force one or zero changes only the indexed flag, one cycle.
// - post-increment load reads at the pointer, then adds one, 2 cycles.
// - pre-decrement load subtracts one, then reads at the pointer, 2 cycles.
// - displaced load reads at second or third pointer plus q, 2 cycles.
// - absolute load reads the address held in the direct register into rd, 2 cycles.
// - post-increment store writes rr at the pointer, adds one, 2 cycles.
// - pre-decrement store subtracts one, then writes rr there, 2 cycles.
//
// Design decisions made here: the APB register port and the address map.
`include "bfls_defines.svh"

module bfls_exec (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [4:0] o_rf_raddr_a,
    output logic [4:0] o_rf_raddr_b,
    output logic [4:0] o_rf_raddr_p,
    input wire logic [15:0] i_rf_rdata_a,
    input wire logic [15:0] i_rf_rdata_b,
    input wire logic [15:0] i_rf_rdata_p,
    output bfls_pkg::bfls_rf_wr_t o_rf_wr,
    output bfls_pkg::bfls_pair_wr_t o_pair_wr,
    output bfls_pkg::bfls_dm_req_t o_dm_req,
    input wire logic [7:0] i_dm_rdata,
    output logic [7:0] o_status_flags,
    output logic o_busy
);

    bfls_pkg::bfls_state_t q;
    bfls_pkg::bfls_state_t d;
    bfls_pkg::bfls_cmd_t new_cmd;
    logic [7:0] alu_res;
    logic [7:0] alu_flags;
    logic [7:0] a_lo;
    logic [7:0] b_lo;
    logic b_sel_bit;
    logic setup;
    logic access_wr;
    logic is_mem;
    logic is_store;
    logic err_now;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic cmd_ok(bfls_pkg::bfls_cmd_t c);
        logic ok;
        ok = 1'b0;
        unique case (c.op)
            bfls_pkg::OP_LOAD_DISP: ok = (c.ptr == 2'h1) || (c.ptr == 2'h2);
            bfls_pkg::OP_LOAD_PTR, bfls_pkg::OP_LOAD_INC,
            bfls_pkg::OP_LOAD_DEC, bfls_pkg::OP_STORE_PTR,
            bfls_pkg::OP_STORE_INC, bfls_pkg::OP_STORE_DEC:
                ok = (c.ptr != 2'h3);
            bfls_pkg::OP_ROTATE_RIGHT_CARRY, bfls_pkg::OP_ARITH_SHIFT_RIGHT,
            bfls_pkg::OP_NIBBLE_SWAP, bfls_pkg::OP_FLAG_FORCE_ONE,
            bfls_pkg::OP_FLAG_FORCE_ZERO, bfls_pkg::OP_REG_BIT_TO_FLAG,
            bfls_pkg::OP_FLAG_TO_REG_BIT, bfls_pkg::OP_REG_COPY,
            bfls_pkg::OP_PAIR_COPY, bfls_pkg::OP_LOAD_ABS: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : cmd_ok

    function automatic logic [4:0] ptr_base(logic [1:0] sel);
        logic [4:0] b;
        b = `BFLS_PTR_FIRST;
        if (sel == 2'h1) begin
            b = `BFLS_PTR_SECOND;
        end else if (sel == 2'h2) begin
            b = `BFLS_PTR_THIRD;
        end
        return b;
    endfunction : ptr_base

    assign new_cmd = bfls_pkg::bfls_cmd_t'(i_pwdata[25:0]);
    assign setup = i_psel && !i_penable;
    assign access_wr = i_psel && i_penable && i_pwrite && !q.pslverr;
    assign a_lo = i_rf_rdata_a[7:0];
    assign b_lo = i_rf_rdata_b[7:0];
    assign b_sel_bit = b_lo[q.cmd.bsel];
    assign is_store = (q.cmd.op == bfls_pkg::OP_STORE_PTR)
        || (q.cmd.op == bfls_pkg::OP_STORE_INC)
        || (q.cmd.op == bfls_pkg::OP_STORE_DEC);
    assign is_mem = is_store || (q.cmd.op == bfls_pkg::OP_LOAD_PTR)
        || (q.cmd.op == bfls_pkg::OP_LOAD_INC)
        || (q.cmd.op == bfls_pkg::OP_LOAD_DEC)
        || (q.cmd.op == bfls_pkg::OP_LOAD_DISP)
        || (q.cmd.op == bfls_pkg::OP_LOAD_ABS);

    bfls_alu u_alu (
        .i_op(q.cmd.op),
        .i_a(a_lo),
        .i_b(b_lo),
        .i_bsel(q.cmd.bsel),
        .i_flags(q.flags),
        .o_res(alu_res),
        .o_flags(alu_flags)
    );

    // ------------------------------------------------------------------
    // register bus decode
    // ------------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        err_now = 1'b0;
        unique case (i_paddr)
            `BFLS_OFF_CMD: begin
                rd_mux = {6'h00, q.cmd};
                err_now = i_pwrite && (o_busy || !cmd_ok(new_cmd));
            end
            `BFLS_OFF_DIRECT: rd_mux = {16'h0000, q.direct};
            `BFLS_OFF_STATUS_FLAGS: begin
                rd_mux = {24'h000000, q.flags};
                err_now = i_pwrite && o_busy;
            end
            `BFLS_OFF_BUSY: begin
                rd_mux = {31'h0000_0000, o_busy};
                err_now = i_pwrite;
            end
            default: err_now = 1'b1;
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        d.rf_wr.we = 1'b0;
        d.pair_wr.we = 1'b0;
        d.dm.re = 1'b0;
        d.dm.we = 1'b0;
        if (setup) begin
            d.prdata = rd_mux;
            d.pslverr = err_now;
        end
        if (access_wr) begin
            unique case (i_paddr)
                `BFLS_OFF_CMD: begin
                    d.cmd = new_cmd;
                    d.phase = bfls_pkg::PH_EXEC;
                end
                `BFLS_OFF_DIRECT: d.direct = i_pwdata[15:0];
                `BFLS_OFF_STATUS_FLAGS: d.flags = i_pwdata[7:0];
                default: d.direct = q.direct;
            endcase
        end
        unique case (q.phase)
            bfls_pkg::PH_IDLE: d.ptr_next = q.ptr_next;
            bfls_pkg::PH_EXEC: begin
                if (is_mem) begin
                    d.phase = bfls_pkg::PH_MEM;
                    d.dm.re = !is_store;
                    d.dm.we = is_store;
                    d.dm.wdata = b_lo;
                    d.dm.addr = i_rf_rdata_p;
                    d.ptr_next = i_rf_rdata_p;
                    unique case (q.cmd.op)
                        bfls_pkg::OP_LOAD_INC, bfls_pkg::OP_STORE_INC:
                            d.ptr_next = i_rf_rdata_p + 16'h0001;
                        bfls_pkg::OP_LOAD_DEC, bfls_pkg::OP_STORE_DEC: begin
                            d.dm.addr = i_rf_rdata_p - 16'h0001;
                            d.ptr_next = i_rf_rdata_p - 16'h0001;
                        end
                        bfls_pkg::OP_LOAD_DISP:
                            d.dm.addr = i_rf_rdata_p
                                + {10'h000, q.cmd.disp};
                        bfls_pkg::OP_LOAD_ABS: d.dm.addr = q.direct;
                        default: d.ptr_next = i_rf_rdata_p;
                    endcase
                end else begin
                    d.phase = bfls_pkg::PH_IDLE;
                    d.flags = alu_flags;
                    if (q.cmd.op == bfls_pkg::OP_PAIR_COPY) begin
                        d.pair_wr.we = 1'b1;
                        d.pair_wr.addr = q.cmd.rd;
                        d.pair_wr.data = i_rf_rdata_b;
                    end else if (q.cmd.op != bfls_pkg::OP_FLAG_FORCE_ONE
                        && q.cmd.op != bfls_pkg::OP_FLAG_FORCE_ZERO
                        && q.cmd.op != bfls_pkg::OP_REG_BIT_TO_FLAG) begin
                        d.rf_wr.we = 1'b1;
                        d.rf_wr.addr = q.cmd.rd;
                        d.rf_wr.data = alu_res;
                    end
                end
            end
            bfls_pkg::PH_MEM: begin
                d.phase = bfls_pkg::PH_IDLE;
                if (!is_store) begin
                    d.rf_wr.we = 1'b1;
                    d.rf_wr.addr = q.cmd.rd;
                    d.rf_wr.data = i_dm_rdata;
                end
                if (q.cmd.op == bfls_pkg::OP_LOAD_INC
                    || q.cmd.op == bfls_pkg::OP_LOAD_DEC
                    || q.cmd.op == bfls_pkg::OP_STORE_INC
                    || q.cmd.op == bfls_pkg::OP_STORE_DEC) begin
                    d.pair_wr.we = 1'b1;
                    d.pair_wr.addr = ptr_base(q.cmd.ptr);
                    d.pair_wr.data = q.ptr_next;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q <= '0;
            q.flags <= `BFLS_RST_FLAGS;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign o_prdata = q.prdata;
    assign o_pready = 1'b1;
    assign o_pslverr = q.pslverr && i_psel && i_penable;
    assign o_rf_raddr_a = q.cmd.rd;
    assign o_rf_raddr_b = q.cmd.rr;
    assign o_rf_raddr_p = ptr_base(q.cmd.ptr);
    assign o_rf_wr = q.rf_wr;
    assign o_pair_wr = q.pair_wr;
    assign o_dm_req = q.dm;
    assign o_status_flags = q.flags;
    assign o_busy = (q.phase != bfls_pkg::PH_IDLE);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic ex;
    assign ex = (q.phase == bfls_pkg::PH_EXEC);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_ror;
        ex && q.cmd.op == bfls_pkg::OP_ROTATE_RIGHT_CARRY |=> o_rf_wr.we
            && o_rf_wr.data == {$past(q.flags[`BFLS_FLAG_C]), $past(a_lo[7:1])}
            && o_status_flags[`BFLS_FLAG_C] == $past(a_lo[0]) && !o_busy;
    endproperty
    a_ror: assert property (p_ror) else $error("rotate result wrong");

    property p_asr;
        ex && q.cmd.op == bfls_pkg::OP_ARITH_SHIFT_RIGHT |=> o_rf_wr.we
            && o_rf_wr.data == {$past(a_lo[7]), $past(a_lo[7:1])}
            && o_status_flags[`BFLS_FLAG_Z] == (o_rf_wr.data == 8'h00);
    endproperty
    a_asr: assert property (p_asr) else $error("shift result wrong");

    property p_bst;
        ex && q.cmd.op == bfls_pkg::OP_REG_BIT_TO_FLAG |=> !o_rf_wr.we
            && o_status_flags[`BFLS_FLAG_T] == $past(b_sel_bit)
            && ((o_status_flags ^ $past(o_status_flags)) & 8'hBF) == 8'h00;
    endproperty
    a_bst: assert property (p_bst) else $error("bit to flag wrong");

    property p_bld;
        ex && q.cmd.op == bfls_pkg::OP_FLAG_TO_REG_BIT |=> o_rf_wr.we
            && o_rf_wr.data[$past(q.cmd.bsel)] == o_status_flags[`BFLS_FLAG_T]
            && $stable(o_status_flags);
    endproperty
    a_bld: assert property (p_bld) else $error("flag to bit wrong");

    property p_force;
        ex && q.cmd.op == bfls_pkg::OP_FLAG_FORCE_ONE |=>
            o_status_flags[$past(q.cmd.bsel)] && !o_busy
            && ((o_status_flags ^ $past(o_status_flags))
            & ~(8'h01 << $past(q.cmd.bsel))) == 8'h00;
    endproperty
    a_force: assert property (p_force) else $error("flag force wrong");

    property p_ld_inc;
        ex && q.cmd.op == bfls_pkg::OP_LOAD_INC |=> o_dm_req.re
            && o_dm_req.addr == $past(i_rf_rdata_p) ##1 o_rf_wr.we
            && o_pair_wr.we && o_pair_wr.data == $past(o_dm_req.addr) + 16'h0001
            && !o_busy;
    endproperty
    a_ld_inc: assert property (p_ld_inc) else $error("load inc wrong");

    property p_ld_dec;
        ex && q.cmd.op == bfls_pkg::OP_LOAD_DEC |=>
            o_dm_req.addr == $past(i_rf_rdata_p) - 16'h0001
            ##1 o_rf_wr.we && o_pair_wr.data == $past(o_dm_req.addr);
    endproperty
    a_ld_dec: assert property (p_ld_dec) else $error("load dec wrong");

    property p_ldd;
        ex && q.cmd.op == bfls_pkg::OP_LOAD_DISP |=>
            o_dm_req.addr == $past(i_rf_rdata_p) + {10'h000, q.cmd.disp}
            ##1 o_rf_wr.we && !o_pair_wr.we && !o_busy;
    endproperty
    a_ldd: assert property (p_ldd) else $error("displaced load wrong");

    property p_lds;
        ex && q.cmd.op == bfls_pkg::OP_LOAD_ABS |=> o_dm_req.addr == q.direct
            ##1 o_rf_wr.data == $past(i_dm_rdata) && $stable(o_status_flags);
    endproperty
    a_lds: assert property (p_lds) else $error("absolute load wrong");

    property p_st_inc;
        ex && q.cmd.op == bfls_pkg::OP_STORE_INC |=> o_dm_req.we
            && o_dm_req.wdata == $past(b_lo) && o_dm_req.addr == $past(i_rf_rdata_p)
            ##1 o_pair_wr.data == $past(o_dm_req.addr) + 16'h0001;
    endproperty
    a_st_inc: assert property (p_st_inc) else $error("store inc wrong");

    property p_st_dec;
        ex && q.cmd.op == bfls_pkg::OP_STORE_DEC |=> o_dm_req.we
            && o_dm_req.addr == $past(i_rf_rdata_p) - 16'h0001
            ##1 o_pair_wr.we && o_pair_wr.data == $past(o_dm_req.addr);
    endproperty
    a_st_dec: assert property (p_st_dec) else $error("store dec wrong");

    property p_swap;
        ex && q.cmd.op == bfls_pkg::OP_NIBBLE_SWAP |=> o_rf_wr.we
            && o_rf_wr.data == {$past(a_lo[3:0]), $past(a_lo[7:4])}
            && $stable(o_status_flags) && !o_busy;
    endproperty
    a_swap: assert property (p_swap) else $error("nibble swap wrong");

endmodule : bfls_exec

// >>> verif/bfls_far_model.sv
// ------------------------------------------------------------
// register file and data memory on the far side
// ------------------------------------------------------------
module bfls_far_model (
    input wire logic i_clk,
    input wire logic [4:0] i_raddr_a,
    input wire logic [4:0] i_raddr_b,
    input wire logic [4:0] i_raddr_p,
    output logic [15:0] o_rdata_a,
    output logic [15:0] o_rdata_b,
    output logic [15:0] o_rdata_p,
    input wire bfls_pkg::bfls_rf_wr_t i_rf_wr,
    input wire bfls_pkg::bfls_pair_wr_t i_pair_wr,
    input wire bfls_pkg::bfls_dm_req_t i_dm_req,
    output logic [7:0] o_dm_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rf [32];
    logic [7:0] mem [65536];
    // combinational reads; memory data garbled outside a read strobe
    always_comb begin
        o_rdata_a = {rf[i_raddr_a + 5'h01], rf[i_raddr_a]};
        o_rdata_b = {rf[i_raddr_b + 5'h01], rf[i_raddr_b]};
        o_rdata_p = {rf[i_raddr_p + 5'h01], rf[i_raddr_p]};
        o_dm_rdata = i_dm_req.re ? mem[i_dm_req.addr] : ~mem[i_dm_req.addr];
    end
    always @(posedge i_clk) begin
        if (i_rf_wr.we) rf[i_rf_wr.addr] <= i_rf_wr.data;
        if (i_pair_wr.we) begin
            rf[i_pair_wr.addr] <= i_pair_wr.data[7:0];
            rf[i_pair_wr.addr + 5'h01] <= i_pair_wr.data[15:8];
        end
        if (i_dm_req.we) mem[i_dm_req.addr] <= i_dm_req.wdata;
    end
endmodule : bfls_far_model

// >>> verif/bfls_exec_tb_top.sv
`include "bfls_defines.svh"
`define BFLS_CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            error_cnt++; \
            $display("unexpected at %0t: got %h exp %h", $time, got, exp); \
        end \
    end
module bfls_exec_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic i_clk, i_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rdat;
    logic [4:0] o_rf_raddr_a, o_rf_raddr_b, o_rf_raddr_p;
    logic [15:0] i_rf_rdata_a, i_rf_rdata_b, i_rf_rdata_p;
    bfls_pkg::bfls_rf_wr_t o_rf_wr;
    bfls_pkg::bfls_pair_wr_t o_pair_wr;
    bfls_pkg::bfls_dm_req_t o_dm_req;
    logic [7:0] i_dm_rdata, o_status_flags;
    logic o_busy, rerr;
    int error_cnt = 0;
    int checks_done = 0;
    logic [7:0] tv [4] = '{8'h01, 8'h80, 8'h81, 8'h02};
    logic [7:0] tres [4] = '{8'h00, 8'hC0, 8'hC0, 8'h01};
    logic [3:0] tflg [4] = '{4'hB, 4'hC, 4'h5, 4'h0};
    bfls_exec dut (.i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite,
        .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
        .o_rf_raddr_a, .o_rf_raddr_b, .o_rf_raddr_p, .i_rf_rdata_a,
        .i_rf_rdata_b, .i_rf_rdata_p, .o_rf_wr, .o_pair_wr, .o_dm_req,
        .i_dm_rdata, .o_status_flags, .o_busy);
    bfls_far_model mdl (.i_clk(i_clk), .i_raddr_a(o_rf_raddr_a),
        .i_raddr_b(o_rf_raddr_b), .i_raddr_p(o_rf_raddr_p),
        .o_rdata_a(i_rf_rdata_a), .o_rdata_b(i_rf_rdata_b),
        .o_rdata_p(i_rf_rdata_p), .i_rf_wr(o_rf_wr),
        .i_pair_wr(o_pair_wr), .i_dm_req(o_dm_req),
        .o_dm_rdata(i_dm_rdata));
    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        @(posedge i_clk);
        while (o_pready !== 1'b1) @(posedge i_clk);
        rdat = o_prdata;
        rerr = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb
    function automatic logic [31:0] mk(input logic [4:0] op,
        input logic [4:0] d, input logic [4:0] s, input logic [2:0] b,
        input logic [1:0] p, input logic [5:0] q);
        return {6'h00, q, p, b, s, d, op};
    endfunction : mk
    task automatic run(input logic [31:0] c, input int cyc, input logic ex);
        int n;
        apb(1'b1, `BFLS_OFF_CMD, c);
        `BFLS_CHK(rerr, ex)
        #1;
        n = 0;
        while (o_busy === 1'b1 && n < 10) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        `BFLS_CHK(n, cyc)
        // far side takes the last strobe one edge after busy falls
        @(posedge i_clk);
        #1;
    endtask : run
    task automatic flg(input logic [7:0] f);
        apb(1'b0, `BFLS_OFF_STATUS_FLAGS, 32'h0);
        `BFLS_CHK(rdat, {24'h0, f})
    endtask : flg
    task automatic final_report;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // ------------------------------------------------------------
    // clock, watchdog, tests
    // ------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    initial begin
        repeat (3000) @(posedge i_clk);
        error_cnt++;
        final_report();
    end
    initial begin
        {i_rst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
        i_rst = 1'b1;
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        flg(8'h00);
        apb(1'b0, `BFLS_OFF_BUSY, 32'h0);
        `BFLS_CHK(rdat, 32'h0)
        apb(1'b0, 12'h010, 32'h0);
        `BFLS_CHK(rerr, 1'b1)
        apb(1'b1, `BFLS_OFF_BUSY, 32'h1);
        `BFLS_CHK(rerr, 1'b1)
        run(mk(5'h11, 5'h00, 5'h00, 3'h0, 2'h0, 6'h00), 0, 1'b1);
        run(mk(5'h0C, 5'h01, 5'h00, 3'h0, 2'h0, 6'h01), 0, 1'b1);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, `BFLS_OFF_STATUS_FLAGS, 32'h00);
            run(mk(5'h03, 5'h00, 5'h00, 3'(i), 2'h0, 6'h00), 1, 1'b0);
            flg(8'h01 << i);
            apb(1'b1, `BFLS_OFF_STATUS_FLAGS, 32'hFF);
            run(mk(5'h04, 5'h00, 5'h00, 3'(i), 2'h0, 6'h00), 1, 1'b0);
            flg(~(8'h01 << i));
        end
        for (int i = 0; i < 4; i++) begin
            mdl.rf[3] = tv[i];
            apb(1'b1, `BFLS_OFF_STATUS_FLAGS, {24'h0, 7'h50, i == 1 || i == 3});
            run(mk(5'(i / 2), 5'h03, 5'h00, 3'h0, 2'h0, 6'h00), 1, 1'b0);
            `BFLS_CHK(mdl.rf[3], tres[i])
            flg({4'hA, tflg[i]});
        end
        mdl.rf[4] = 8'h3C;
        mdl.rf[10] = 8'h20;
        mdl.rf[11] = 8'h00;
        apb(1'b1, `BFLS_OFF_STATUS_FLAGS, 32'h1A);
        run(mk(5'h02, 5'h04, 5'h00, 3'h0, 2'h0, 6'h00), 1, 1'b0);
        run(mk(5'h07, 5'h05, 5'h04, 3'h0, 2'h0, 6'h00), 1, 1'b0);
        run(mk(5'h08, 5'h08, 5'h04, 3'h0, 2'h0, 6'h00), 1, 1'b0);
        `BFLS_CHK({mdl.rf[9], mdl.rf[8]}, 16'hC3C3)
        flg(8'h1A);
        run(mk(5'h05, 5'h00, 5'h0A, 3'h5, 2'h0, 6'h00), 1, 1'b0);
        flg(8'h5A);
        run(mk(5'h06, 5'h0B, 5'h00, 3'h7, 2'h0, 6'h00), 1, 1'b0);
        `BFLS_CHK(mdl.rf[11], 8'h80)
        flg(8'h5A);
        {mdl.rf[29], mdl.rf[28]} = 16'h0110;
        {mdl.rf[31], mdl.rf[30]} = 16'h0300;
        {mdl.mem[16'h0110], mdl.mem[16'h0111]} = 16'h5A77;
        mdl.mem[16'h0113] = 8'h3E;
        mdl.mem[16'h0200] = 8'hC1;
        run(mk(5'h0A, 5'h0C, 5'h00, 3'h0, 2'h1, 6'h00), 2, 1'b0);
        `BFLS_CHK({mdl.rf[29], mdl.rf[28], mdl.rf[12]}, 24'h01115A)
        run(mk(5'h0B, 5'h0D, 5'h00, 3'h0, 2'h1, 6'h00), 2, 1'b0);
        `BFLS_CHK({mdl.rf[29], mdl.rf[28], mdl.rf[13]}, 24'h01105A)
        run(mk(5'h0C, 5'h0E, 5'h00, 3'h0, 2'h1, 6'h03), 2, 1'b0);
        `BFLS_CHK({mdl.rf[29], mdl.rf[28], mdl.rf[14]}, 24'h01103E)
        apb(1'b1, `BFLS_OFF_DIRECT, 32'h0200);
        run(mk(5'h0D, 5'h0F, 5'h00, 3'h0, 2'h0, 6'h00), 2, 1'b0);
        `BFLS_CHK(mdl.rf[15], 8'hC1)
        run(mk(5'h0F, 5'h00, 5'h04, 3'h0, 2'h2, 6'h00), 2, 1'b0);
        `BFLS_CHK({mdl.rf[31], mdl.rf[30], mdl.mem[16'h0300]}, 24'h0301C3)
        run(mk(5'h10, 5'h00, 5'h0A, 3'h0, 2'h2, 6'h00), 2, 1'b0);
        `BFLS_CHK({mdl.rf[31], mdl.rf[30], mdl.mem[16'h0300]}, 24'h030020)
        flg(8'h5A);
        final_report();
    end
endmodule : bfls_exec_tb_top
